// [design/framer_mode_pkg.sv]
// constants, types and register map of the framer mode-control slice
package framer_mode_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SETTLE_TIME_US = 20;
    // longest settle time, rounded down to whole cycles
    localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W = 12;

    // ==========================================================
    // register offsets (byte addresses on the bus)
    localparam logic [7:0] MODE_CTRL_OFS = 8'h00;
    localparam logic [7:0] AUX_CTRL_OFS = 8'h04;
    localparam logic [7:0] TX_DL1_OFS = 8'h08;
    localparam logic [7:0] TX_DL2_OFS = 8'h0C;
    localparam logic [7:0] TX_DL3_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] FIFO_DATA_OFS = 8'h18;
    localparam logic [7:0] CRC_ERR_OFS = 8'h1C;

    // ==========================================================
    // framer_mode_control_one fields
    localparam int unsigned CHAN_TRANS_BIT = 7;
    localparam int unsigned DL_INSERT_BIT = 6;
    localparam int unsigned LINE_STD_BIT = 5;
    localparam int unsigned CRC_BIT = 4;
    localparam int unsigned ERR_LATCH_BIT = 3;
    localparam int unsigned SYS_RATE_LOW_BIT = 2;
    localparam int unsigned TX_ALARM_BIT = 1;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_CTRL_MASK = 8'hFE;

    // auxiliary control fields
    localparam int unsigned DL_FIFO_EN_BIT = 0;
    localparam int unsigned TRANSPARENT_BIT = 1;
    localparam int unsigned FMT_LSB = 2;
    localparam int unsigned JAPAN_BIT = 4;
    localparam logic [7:0] AUX_CTRL_RST = 8'h00;
    localparam logic [7:0] AUX_CTRL_MASK = 8'h1F;

    // status fields
    localparam int unsigned ST_SETTLING_BIT = 0;
    localparam int unsigned ST_LINE_STD_BIT = 1;
    localparam int unsigned ST_FIFO_EMPTY_BIT = 2;
    localparam int unsigned ST_FIFO_FULL_BIT = 3;

    localparam logic [7:0] TX_DL_RST = 8'h00;
    localparam logic [3:0] DL_BITS_PER_REG = 4'h8;
    localparam logic [1:0] DL_LAST_REG = 2'h2;

    // ==========================================================
    // frame formats
    typedef enum logic [1:0] {
        FMT_F12 = 2'b00,
        FMT_F4 = 2'b01,
        FMT_ESF = 2'b10,
        FMT_F72 = 2'b11
    } frame_format_t;

    // link-side pins, sampled as one group
    typedef struct packed {
        logic clk;
        logic data;
        logic dl_slot;
        logic crc_slot;
        logic crc_bit;
        logic crc_err;
    } link_in_t;

    localparam link_in_t LINK_IN_RST = '0;

endpackage

// [design/framer_mode_control.sv]
// framer mode-control slice: register file, data-link source select, crc6 control
// ==========================================================
`timescale 1ns/1ps

// ==========================================================
// signaling fifo
module sig_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // full and empty from the true occupancy count
    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // storage has no reset; only pointers and the occupancy count need a defined value
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end
endmodule

// ==========================================================
// top: wishbone slave plus transmit bit selection
module framer_mode_control #(
    parameter int unsigned FIFO_DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    input wire framer_mode_pkg::link_in_t link_pins_in,
    output logic tx_line_data_out,
    output logic channel_translation_out,
    output logic line_standard_out,
    output logic japan_t1_out,
    output logic clock_settling_out
);
    import framer_mode_pkg::*;

    // ==========================================================
    // declarations
    logic [7:0] mode_ctrl_r;
    logic [7:0] aux_ctrl_r;
    logic [7:0] tx_dl_r [3];
    logic [7:0] crc_err_cnt_r;
    logic [SETTLE_CNT_W-1:0] settle_cnt_r;
    link_in_t link_meta_r;
    link_in_t link_sync_r;
    logic link_clk_prev_r;
    logic [1:0] dl_reg_idx_r;
    logic [2:0] dl_bit_idx_r;
    logic [7:0] dl_shift_r;
    logic [3:0] dl_bits_left_r;
    logic req;
    logic mapped;
    logic fifo_wr;
    logic take;
    logic link_edge;
    logic fmt_dl_capable;
    logic reg_insert;
    logic esf_mode;
    logic crc_enable;
    logic dl_consume_fifo;
    logic dl_consume_regs;
    logic tx_bit_nxt;
    logic dl_bit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [7:0] rd_data;
    frame_format_t frame_format;

    // ==========================================================
    // bus decode; a fifo write with the fifo full is held until room appears
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    assign fifo_wr = req && wb_we_in && (wb_adr_in == FIFO_DATA_OFS);
    assign take = req && (!fifo_wr || fifo_in_ready);
    always_comb begin
        case (wb_adr_in)
            MODE_CTRL_OFS, AUX_CTRL_OFS, TX_DL1_OFS, TX_DL2_OFS, TX_DL3_OFS,
            STATUS_OFS, FIFO_DATA_OFS, CRC_ERR_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // read mux; fifo data port reads as zero
    always_comb begin
        case (wb_adr_in)
            MODE_CTRL_OFS: rd_data = mode_ctrl_r;
            AUX_CTRL_OFS: rd_data = aux_ctrl_r;
            TX_DL1_OFS: rd_data = tx_dl_r[0];
            TX_DL2_OFS: rd_data = tx_dl_r[1];
            TX_DL3_OFS: rd_data = tx_dl_r[2];
            STATUS_OFS: begin
                rd_data = 8'h00;
                rd_data[ST_SETTLING_BIT] = clock_settling_out;
                rd_data[ST_LINE_STD_BIT] = mode_ctrl_r[LINE_STD_BIT];
                rd_data[ST_FIFO_EMPTY_BIT] = !fifo_out_valid;
                rd_data[ST_FIFO_FULL_BIT] = !fifo_in_ready;
            end
            CRC_ERR_OFS: rd_data = crc_err_cnt_r;
            default: rd_data = 8'h00;
        endcase
    end

    // answer one cycle after the request is taken; ack or err drops next cycle
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            wb_err_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= take && mapped;
            wb_err_out <= take && !mapped;
            if (take) begin
                wb_dat_out <= {24'h00_0000, rd_data};
            end
        end
    end

    // ==========================================================
    // control registers; only byte lane 0 carries data
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            mode_ctrl_r <= MODE_CTRL_RST;
            aux_ctrl_r <= AUX_CTRL_RST;
        end else if (take && wb_we_in && wb_sel_in[0]) begin
            if (wb_adr_in == MODE_CTRL_OFS) begin
                mode_ctrl_r <= wb_dat_in[7:0] & MODE_CTRL_MASK;
            end
            if (wb_adr_in == AUX_CTRL_OFS) begin
                aux_ctrl_r <= wb_dat_in[7:0] & AUX_CTRL_MASK;
            end
        end
    end

    // transmit data-link registers
    generate
        for (genvar i = 0; i < 3; i++) begin : g_dl
            always_ff @(posedge ref_clk_in) begin
                if (!reset_n_in) begin
                    tx_dl_r[i] <= TX_DL_RST;
                end else if (take && wb_we_in && wb_sel_in[0] && (wb_adr_in == TX_DL1_OFS + 8'(4 * i))) begin
                    tx_dl_r[i] <= wb_dat_in[7:0];
                end
            end
        end
    endgenerate

    // settle timer restarts on every change of line standard
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            settle_cnt_r <= '0;
            clock_settling_out <= 1'b0;
        end else begin
            if (take && wb_we_in && wb_sel_in[0] && (wb_adr_in == MODE_CTRL_OFS)
                && (wb_dat_in[LINE_STD_BIT] != mode_ctrl_r[LINE_STD_BIT])) begin
                settle_cnt_r <= SETTLE_CNT_W'(SETTLE_CYCLES);
                clock_settling_out <= 1'b1;
            end else if (settle_cnt_r != '0) begin
                settle_cnt_r <= settle_cnt_r - 1'b1;
                clock_settling_out <= (settle_cnt_r != SETTLE_CNT_W'(1));
            end else begin
                clock_settling_out <= 1'b0;
            end
        end
    end

    // mode outputs registered so they change one cycle after the register, two cycles after the write is taken
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            channel_translation_out <= 1'b0;
            line_standard_out <= 1'b0;
            japan_t1_out <= 1'b0;
        end else begin
            channel_translation_out <= mode_ctrl_r[CHAN_TRANS_BIT];
            line_standard_out <= mode_ctrl_r[LINE_STD_BIT];
            japan_t1_out <= aux_ctrl_r[JAPAN_BIT] && mode_ctrl_r[LINE_STD_BIT];
        end
    end

    // ==========================================================
    // link pins: two flip-flops, then edge detect on the synced clock only
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            link_meta_r <= LINK_IN_RST;
            link_sync_r <= LINK_IN_RST;
            link_clk_prev_r <= 1'b0;
        end else begin
            link_meta_r <= link_pins_in;
            link_sync_r <= link_meta_r;
            link_clk_prev_r <= link_sync_r.clk;
        end
    end
    assign link_edge = link_sync_r.clk && !link_clk_prev_r;

    // ==========================================================
    // mode decode
    assign frame_format = frame_format_t'(aux_ctrl_r[FMT_LSB +: 2]);
    assign fmt_dl_capable = (frame_format == FMT_F4) || (frame_format == FMT_ESF)
                            || (frame_format == FMT_F72);
    // transparent mode wins over register insertion
    assign reg_insert = mode_ctrl_r[DL_INSERT_BIT] && fmt_dl_capable && !aux_ctrl_r[TRANSPARENT_BIT];
    assign esf_mode = (frame_format == FMT_ESF);
    assign crc_enable = esf_mode && mode_ctrl_r[CRC_BIT];
    assign dl_consume_regs = link_edge && link_sync_r.dl_slot && reg_insert;
    assign dl_consume_fifo = link_edge && link_sync_r.dl_slot && !reg_insert
                             && aux_ctrl_r[DL_FIFO_EN_BIT] && (dl_bits_left_r != 4'h0);
    // an empty shifter pulls the next byte from the fifo
    assign fifo_out_ready = (dl_bits_left_r == 4'h0);

    // data-link bit source
    always_comb begin
        if (reg_insert) begin
            dl_bit = tx_dl_r[dl_reg_idx_r][dl_bit_idx_r];
        end else if (aux_ctrl_r[DL_FIFO_EN_BIT]) begin
            // underrun sends idle ones rather than stale data
            dl_bit = (dl_bits_left_r != 4'h0) ? dl_shift_r[0] : 1'b1;
        end else begin
            dl_bit = link_sync_r.data;
        end
    end

    // final transmit bit per slot type
    always_comb begin
        if (link_sync_r.dl_slot) begin
            tx_bit_nxt = dl_bit;
        end else if (link_sync_r.crc_slot && esf_mode) begin
            tx_bit_nxt = crc_enable ? link_sync_r.crc_bit : 1'b1;
        end else begin
            tx_bit_nxt = link_sync_r.data;
        end
    end

    // line output updates once per link clock edge
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            tx_line_data_out <= 1'b1;
        end else if (link_edge) begin
            tx_line_data_out <= tx_bit_nxt;
        end
    end

    // walk through the three registers, lsb first
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            dl_reg_idx_r <= 2'h0;
            dl_bit_idx_r <= 3'h0;
        end else if (dl_consume_regs) begin
            dl_bit_idx_r <= dl_bit_idx_r + 1'b1;
            if (dl_bit_idx_r == 3'h7) begin
                dl_reg_idx_r <= (dl_reg_idx_r == DL_LAST_REG) ? 2'h0 : dl_reg_idx_r + 1'b1;
            end
        end
    end

    // fifo byte shifter
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            dl_shift_r <= 8'h00;
            dl_bits_left_r <= 4'h0;
        end else if (fifo_out_ready && fifo_out_valid) begin
            dl_shift_r <= fifo_out_data;
            dl_bits_left_r <= DL_BITS_PER_REG;
        end else if (dl_consume_fifo) begin
            dl_shift_r <= {1'b0, dl_shift_r[7:1]};
            dl_bits_left_r <= dl_bits_left_r - 1'b1;
        end
    end

    // crc6 error count: counted only while checking is on; event beats clear
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            crc_err_cnt_r <= 8'h00;
        end else begin
            if (link_edge && link_sync_r.crc_err && crc_enable) begin
                if (take && !wb_we_in && (wb_adr_in == CRC_ERR_OFS)) begin
                    crc_err_cnt_r <= 8'h01;
                end else if (crc_err_cnt_r != 8'hFF) begin
                    crc_err_cnt_r <= crc_err_cnt_r + 1'b1;
                end
            end else if (take && !wb_we_in && (wb_adr_in == CRC_ERR_OFS)) begin
                crc_err_cnt_r <= 8'h00;
            end
        end
    end

    // ==========================================================
    // signaling fifo in the data-link path
    sig_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(fifo_wr),
        .in_ready_out(fifo_in_ready),
        .in_data_in(wb_dat_in[7:0]),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );
endmodule

// [test/framer_mode_control_monitor.sv]
// assertion checker bound to the framer mode-control top
`timescale 1ns/1ps
module framer_mode_monitor
    import framer_mode_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 16
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    input wire logic channel_translation_out,
    input wire logic line_standard_out,
    input wire logic japan_t1_out,
    input wire logic clock_settling_out
);
    // ==========================================================
    // helpers
    logic take;
    logic [SETTLE_CNT_W-1:0] settle_cnt_r;
    assign take = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    // counts settling cycles so the length is bounded to within one cycle of SETTLE_CYCLES, not just eventually
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || !clock_settling_out) begin
            settle_cnt_r <= '0;
        end else begin
            settle_cnt_r <= settle_cnt_r + 1'b1;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // ==========================================================
    // properties
    sequence s_mode_wr;
        take && wb_we_in && wb_sel_in[0] && wb_adr_in == MODE_CTRL_OFS;
    endsequence
    sequence s_mode_rd;
        take && !wb_we_in && wb_adr_in == MODE_CTRL_OFS;
    endsequence
    property p_ctm_follow;
        s_mode_wr |-> ##2 channel_translation_out == $past(wb_dat_in[CHAN_TRANS_BIT], 2);
    endproperty
    property p_std_follow;
        s_mode_wr |-> ##2 line_standard_out == $past(wb_dat_in[LINE_STD_BIT], 2);
    endproperty
    property p_settle_rise;
        $changed(line_standard_out) |-> ##[0:1] clock_settling_out;
    endproperty
    property p_settle_len;
        $fell(clock_settling_out) |-> settle_cnt_r inside {[SETTLE_CYCLES - 1:SETTLE_CYCLES + 1]};
    endproperty
    property p_japan;
        japan_t1_out |-> line_standard_out || $past(line_standard_out);
    endproperty
    property p_ack_pulse;
        wb_ack_out || wb_err_out |=> !wb_ack_out && !wb_err_out;
    endproperty
    property p_read_answer;
        s_mode_rd |=> wb_ack_out && !wb_err_out;
    endproperty
    property p_err_unmapped;
        take && wb_adr_in >= 8'h20 |=> wb_err_out && !wb_ack_out;
    endproperty
    property p_dat_upper;
        wb_ack_out |-> wb_dat_out[31:8] == 24'h000000;
    endproperty
    a_ctm_follow: assert property (p_ctm_follow) else $error("channel translation output wrong");
    a_std_follow: assert property (p_std_follow) else $error("line standard output wrong");
    a_settle_rise: assert property (p_settle_rise) else $error("settling not raised");
    a_settle_len: assert property (p_settle_len) else $error("settling length wrong");
    a_japan: assert property (p_japan) else $error("japan select without T1");
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
    a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_dat_upper: assert property (p_dat_upper) else $error("upper read bits not zero");
endmodule

bind framer_mode_control framer_mode_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out),
    .channel_translation_out(channel_translation_out), .line_standard_out(line_standard_out),
    .japan_t1_out(japan_t1_out), .clock_settling_out(clock_settling_out)
);

// [test/link_partner.sv]
// behavioural line equipment driving the link pins
`timescale 1ns/1ps
module link_partner
    import framer_mode_pkg::*;
(
    input wire logic tx_in,
    output link_in_t pins_out
);
    // ==========================================================
    // one link bit per call; the clock stands low between calls
    initial pins_out = LINK_IN_RST;
    // f is {dl_slot, crc_slot, crc_bit, crc_err, data}; got is the transmitted bit
    task automatic send_bit(input logic [4:0] f, output logic got);
        {pins_out.dl_slot, pins_out.crc_slot, pins_out.crc_bit, pins_out.crc_err, pins_out.data} = f;
        #62.5 pins_out.clk = 1'b1;
        // sampled late in the high phase, past the few-cycle sync delay
        #60 got = tx_in;
        #2.5 pins_out.clk = 1'b0;
        // released data shows the inverse so a stale value never passes
        pins_out.data = ~f[0];
    endtask
endmodule

// [test/e1_t1_framer_mode_control_tb.sv]
// self-checking bench for the framer mode-control slice
`timescale 1ns/1ps
module e1_t1_framer_mode_control_tb;
    import framer_mode_pkg::*;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack, wb_err, tx_bit, chan_tr, line_std, japan, settling, er, got;
    link_in_t link_pins;
    logic [31:0] rd;
    logic [7:0] eb;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    // rows: aux, mode, link flags {dl, crc slot, crc bit, crc err, data}, expected bit
    logic [21:0] rows [12] = '{
        {8'h00, 8'h40, 5'h11, 1'b1}, {8'h04, 8'h40, 5'h11, 1'b0}, {8'h08, 8'h40, 5'h11, 1'b0},
        {8'h0C, 8'h40, 5'h11, 1'b0}, {8'h06, 8'h40, 5'h11, 1'b1}, {8'h04, 8'h00, 5'h11, 1'b1},
        {8'h05, 8'h00, 5'h10, 1'b1}, {8'h05, 8'h40, 5'h11, 1'b0}, {8'h08, 8'h00, 5'h0A, 1'b1},
        {8'h08, 8'h10, 5'h0B, 1'b0}, {8'h04, 8'h10, 5'h0A, 1'b0}, {8'h00, 8'h00, 5'h01, 1'b1}
    };
    framer_mode_control #(.FIFO_DEPTH(16)) dut (
        .ref_clk_in(clk), .reset_n_in(reset_n), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
        .wb_err_out(wb_err), .link_pins_in(link_pins), .tx_line_data_out(tx_bit),
        .channel_translation_out(chan_tr), .line_standard_out(line_std), .japan_t1_out(japan),
        .clock_settling_out(settling)
    );
    link_partner lnk (.tx_in(tx_bit), .pins_out(link_pins));
    always #5 clk = ~clk;
    // ==========================================================
    // tasks
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle held until ack or err is sampled at a rising edge
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rdat,
                       output logic err);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'h1;
        wb_wdat <= {24'h000000, dat};
        @(posedge clk);
        while (wb_ack !== 1'b1 && wb_err !== 1'b1) @(posedge clk);
        rdat = wb_rdat;
        err = wb_err;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] r;
        logic e;
        bus(1'b1, adr, dat, r, e);
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00, rd, er);
        check(rd, {24'h000000, exp});
    endtask
    // bounded wait: software must not rely on the line before settling ends
    task automatic wait_settle;
        int n;
        n = 0;
        while (settling === 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check(32'(settling), 32'h0);
    endtask
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // ==========================================================
    // sequence
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        check(32'({tx_bit, chan_tr, line_std, japan, settling}), 32'h10);
        for (int i = 0; i < 8; i++) rdchk(8'(i * 4), (i == 5) ? 8'h04 : 8'h00);
        bus(1'b0, 8'h20, 8'h00, rd, er);
        check(32'(er), 32'h1);
        // table of source selections; data-link regs stay zero so they differ from data
        for (int i = 1; i < 4; i++) wr(8'(4 + 4 * i), 8'h00);
        for (int i = 0; i < 12; i++) begin
            wr(AUX_CTRL_OFS, rows[i][21:14]);
            wr(MODE_CTRL_OFS, rows[i][13:6]);
            lnk.send_bit(rows[i][5:1], got);
            check(32'(got), 32'(rows[i][0]));
        end
        rdchk(CRC_ERR_OFS, 8'h01);
        rdchk(CRC_ERR_OFS, 8'h00);
        // mode bits, standard switch and settle
        wr(AUX_CTRL_OFS, 8'h10);
        wr(MODE_CTRL_OFS, 8'hFF);
        rdchk(MODE_CTRL_OFS, 8'hFE);
        check(32'({chan_tr, line_std, japan, settling}), 32'hF);
        rdchk(STATUS_OFS, 8'h07);
        wait_settle();
        wr(MODE_CTRL_OFS, 8'h00);
        rdchk(MODE_CTRL_OFS, 8'h00);
        check(32'({chan_tr, line_std, japan, settling}), 32'h1);
        wait_settle();
        // fifo filled to refusal, the extra write waits while the link drains
        wr(AUX_CTRL_OFS, 8'h01);
        // the shifter takes the first byte at once, so full needs one byte more than the depth
        for (int i = 0; i < 17; i++) wr(FIFO_DATA_OFS, 8'h30 + 8'(i));
        rdchk(STATUS_OFS, 8'h08);
        fork
            wr(FIFO_DATA_OFS, 8'h5A);
            for (int b = 0; b < 18; b++) begin
                eb = (b < 17) ? 8'h30 + 8'(b) : 8'h5A;
                for (int j = 0; j < 8; j++) begin
                    lnk.send_bit({4'h8, ~eb[j]}, got);
                    check(32'(got), 32'(eb[j]));
                end
            end
        join
        lnk.send_bit(5'h10, got);
        check(32'(got), 32'h1);
        rdchk(STATUS_OFS, 8'h04);
        // reset in mid-run
        wr(MODE_CTRL_OFS, 8'h80);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(MODE_CTRL_OFS, 8'h00);
        check(32'({tx_bit, chan_tr}), 32'h2);
        conclude();
    end
endmodule
